// file: hdl/rmc_top.sv
/*
 * rmc_top: reset pin sequencing, reset cause capture, operating mode entry,
 * debug pin drive with speedup pulses, and the root clock enables.
 * Assumes all inputs are synchronous to mclk except the timer external
 * clocks, which are synchronised here; clock inputs arrive as enable pulses.
 */
module rmc_top
    import rmc_pkg::*;
#(
    parameter int LPO_DIV_P = LPO_DIV
)
(
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // root clock enables in
    input  wire logic                   ext_ref_clk_en,
    input  wire logic                   int_ref_clk_en,
    input  wire logic                   fixed_freq_clk_en,
    input  wire logic                   debug_link_clk_en,
    input  wire logic [NUM_TIMERS-1:0]  timer_ext_clk,
    input  wire rmc_clk_sel_t           clk_sel,
    // clock enables out
    output logic                        bus_clk_en,
    output logic                        lpo_clk_en,
    output rmc_clk_en_t                 clk_en,
    // reset sources and reset pin
    input  wire rmc_rst_req_t           rst_req,
    input  wire logic                   reset_pin_in,
    output logic                        reset_pin_out,
    output logic                        reset_pin_oe,
    // system state
    output logic                        sys_reset,
    output logic [CAUSE_W-1:0]          reset_cause_status_register,
    output rmc_mode_t                   op_mode,
    input  wire logic                   clkgen_ext_req,
    output logic                        clkgen_use_internal,
    // debug pin and bit timing
    input  wire logic                   debug_pin_in,
    output logic                        debug_pin_out,
    output logic                        debug_pin_oe,
    input  wire logic                   bdc_drive_low,
    input  wire logic                   bdc_bit_run,
    output logic                        bdc_bit_tick
);

    localparam int         LPO_W    = $clog2(LPO_DIV_P);
    localparam logic [6:0] DRV_LAST = 7'(RST_DRIVE_MCLK - 1);
    localparam logic [3:0] BIT_LAST = 4'(BDC_BIT_CLKS - 1);
    localparam logic [1:0] SPD_LEN  = 2'(SPEEDUP_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // bus clock and low-power clock dividers
    logic [LPO_W-1:0] lpo_cnt;
    logic [LPO_W-1:0] next_lpo_cnt;
    logic             next_bus_clk_en;
    logic             next_lpo_clk_en;

    always_comb
    begin
        next_bus_clk_en = !bus_clk_en;
        next_lpo_clk_en = (lpo_cnt == LPO_W'(LPO_DIV_P - 1));
        next_lpo_cnt    = next_lpo_clk_en ? '0 : lpo_cnt + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            bus_clk_en <= 1'b0;
            lpo_clk_en <= 1'b0;
            lpo_cnt    <= '0;
        end
        else
        begin
            bus_clk_en <= next_bus_clk_en;
            lpo_clk_en <= next_lpo_clk_en;
            lpo_cnt    <= next_lpo_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer external clock synchronisers, stepped on the bus enable
    logic [NUM_TIMERS-1:0] tsync1;
    logic [NUM_TIMERS-1:0] tsync2;
    logic [NUM_TIMERS-1:0] tsync3;
    logic [NUM_TIMERS-1:0] next_tsync1;
    logic [NUM_TIMERS-1:0] next_tsync2;
    logic [NUM_TIMERS-1:0] next_tsync3;
    logic [NUM_TIMERS-1:0] tmr_ext_edge;

    always_comb
    begin
        next_tsync1  = bus_clk_en ? timer_ext_clk : tsync1;
        next_tsync2  = bus_clk_en ? tsync1 : tsync2;
        next_tsync3  = bus_clk_en ? tsync2 : tsync3;
        // one pulse per rising edge; faster inputs than half bus rate lose edges
        tmr_ext_edge = {NUM_TIMERS{bus_clk_en}} & tsync2 & ~tsync3;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tsync1 <= '0;
            tsync2 <= '0;
            tsync3 <= '0;
        end
        else
        begin
            tsync1 <= next_tsync1;
            tsync2 <= next_tsync2;
            tsync3 <= next_tsync3;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // clock routing to modules
    always_comb
    begin
        clk_en = '0;
        unique case (clk_sel.rtc)
            RTC_SEL_LPO: clk_en.rtc = lpo_clk_en;
            RTC_SEL_EXT: clk_en.rtc = ext_ref_clk_en;
            RTC_SEL_INT: clk_en.rtc = int_ref_clk_en;
            RTC_SEL_OFF: clk_en.rtc = 1'b0;
        endcase
        clk_en.wdog = (clk_sel.wdog == WDOG_SEL_LPO) ? lpo_clk_en : bus_clk_en;
        clk_en.adc  = clk_sel.adc_alt ? ext_ref_clk_en : bus_clk_en;
        clk_en.can  = clk_sel.can_alt ? ext_ref_clk_en : bus_clk_en;
        for (int t = 0; t < NUM_TIMERS; t++)
        begin
            unique case (clk_sel.tmr[2*t +: 2])
                TMR_SEL_BUS: clk_en.tmr[t] = bus_clk_en;
                TMR_SEL_FIX: clk_en.tmr[t] = fixed_freq_clk_en;
                TMR_SEL_EXT: clk_en.tmr[t] = tmr_ext_edge[t];
                TMR_SEL_OFF: clk_en.tmr[t] = 1'b0;
            endcase
        end
        // debug clock: the debug link enable when selected, else the bus enable
        clk_en.bdc = clk_sel.dbg_link ? debug_link_clk_en : bus_clk_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencer, cause capture and mode latch
    rmc_state_t         state;
    rmc_state_t         next_state;
    logic [6:0]         drive_cnt;
    logic [6:0]         next_drive_cnt;
    logic [CAUSE_W-1:0] next_cause;
    rmc_mode_t          next_mode;
    logic               next_clk_int;

    always_comb
    begin
        next_state     = state;
        next_drive_cnt = drive_cnt;
        next_cause     = reset_cause_status_register;
        next_mode      = op_mode;
        unique case (state)
            RS_DRIVE:
            begin
                // 68 mclk = 34 bus cycles
                if (drive_cnt == DRV_LAST)
                    next_state = RS_RELEASE;
                else
                    next_drive_cnt = drive_cnt + 1'b1;
            end
            RS_RELEASE:
            begin
                if (reset_pin_in)
                begin
                    next_state = RS_RUN;
                    next_mode  = debug_pin_in ? MODE_NORMAL : MODE_DEBUG;
                end
            end
            RS_RUN:
            begin
                if ((|rst_req) || !reset_pin_in)
                begin
                    next_state     = RS_DRIVE;
                    next_drive_cnt = '0;
                    next_cause     = '0;
                    if (rst_req.lvd)
                        next_cause[CAUSE_LVD] = 1'b1;
                    else if (rst_req.loc)
                        next_cause[CAUSE_LOC] = 1'b1;
                    else if (rst_req.watchdog)
                        next_cause[CAUSE_COP] = 1'b1;
                    else if (rst_req.ilop)
                        next_cause[CAUSE_ILOP] = 1'b1;
                    else if (rst_req.ilad)
                        next_cause[CAUSE_ILAD] = 1'b1;
                    else
                        next_cause[CAUSE_PIN] = 1'b1;
                end
            end
        endcase
        next_clk_int = (next_state != RS_RUN) || !clkgen_ext_req;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state                       <= RS_DRIVE;
            drive_cnt                   <= '0;
            reset_cause_status_register <= CAUSE_RESET;
            op_mode                     <= MODE_NORMAL;
            clkgen_use_internal         <= 1'b1;
        end
        else
        begin
            state                       <= next_state;
            drive_cnt                   <= next_drive_cnt;
            reset_cause_status_register <= next_cause;
            op_mode                     <= next_mode;
            clkgen_use_internal         <= next_clk_int;
        end
    end

    // open-drain: the pin level is only ever pulled low here
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = (state == RS_DRIVE);
    assign sys_reset     = (state != RS_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // debug pin drive and bit timing
    logic       drive_low_q;
    logic       next_drive_low_q;
    logic [1:0] spd_cnt;
    logic [1:0] next_spd_cnt;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic       next_pin_oe;
    logic       next_pin_out;

    always_comb
    begin
        next_drive_low_q = bdc_drive_low && (state == RS_RUN);
        next_spd_cnt     = '0;
        next_pin_oe      = 1'b0;
        next_pin_out     = 1'b0;
        if (state == RS_RUN)
        begin
            if (drive_low_q && !bdc_drive_low)
                next_spd_cnt = SPD_LEN;
            else if (spd_cnt != 2'h0 && !bdc_drive_low)
                next_spd_cnt = spd_cnt - 1'b1;
            next_pin_oe  = bdc_drive_low || (next_spd_cnt != 2'h0);
            next_pin_out = !bdc_drive_low;
        end
        if (!bdc_bit_run)
            next_bit_cnt = '0;
        else if (clk_en.bdc)
            next_bit_cnt = bit_cnt + 1'b1;
        else
            next_bit_cnt = bit_cnt;
        bdc_bit_tick = bdc_bit_run && clk_en.bdc && (bit_cnt == BIT_LAST);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            drive_low_q   <= 1'b0;
            spd_cnt       <= '0;
            bit_cnt       <= '0;
            debug_pin_oe  <= 1'b0;
            debug_pin_out <= 1'b0;
        end
        else
        begin
            drive_low_q   <= next_drive_low_q;
            spd_cnt       <= next_spd_cnt;
            bit_cnt       <= next_bit_cnt;
            debug_pin_oe  <= next_pin_oe;
            debug_pin_out <= next_pin_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [7:0] drive_len;
    logic [4:0] bdc_seen;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            drive_len <= 8'h00;
            bdc_seen  <= '0;
        end
        else
        begin
            drive_len <= reset_pin_oe ? drive_len + 1'b1 : 8'h00;
            if (!bdc_bit_run || bdc_bit_tick)
                bdc_seen <= '0;
            else if (clk_en.bdc)
                bdc_seen <= bdc_seen + 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_bus_half_rate: assert property (
        bus_clk_en |=> !bus_clk_en ##1 bus_clk_en)
        else $error("bus enable not every second cycle");
    a_wdog_lpo_route: assert property (
        (clk_sel.wdog == WDOG_SEL_LPO) |-> (clk_en.wdog == lpo_clk_en))
        else $error("watchdog not on low-power clock");
    a_rtc_ext_route: assert property (
        (clk_sel.rtc == RTC_SEL_EXT) && clk_sel.can_alt |->
        (clk_en.rtc == ext_ref_clk_en) && (clk_en.can == ext_ref_clk_en))
        else $error("external reference not routed");
    a_rtc_int_route: assert property (
        (clk_sel.rtc == RTC_SEL_INT) |-> (clk_en.rtc == int_ref_clk_en))
        else $error("internal reference not routed to rtc");
    a_tmr_fixed_route: assert property (
        (clk_sel.tmr[1:0] == TMR_SEL_FIX) |-> (clk_en.tmr[0] == fixed_freq_clk_en))
        else $error("fixed clock not routed to timer");
    a_tmr_ext_sync: assert property (
        (clk_sel.tmr[1:0] == TMR_SEL_EXT) && clk_en.tmr[0] |-> bus_clk_en)
        else $error("timer external edge off the bus enable");
    a_bdc_link_route: assert property (
        clk_sel.dbg_link |-> (clk_en.bdc == debug_link_clk_en))
        else $error("debug link clock not used");
    a_clk_internal_reset: assert property (
        sys_reset ##1 sys_reset |-> clkgen_use_internal)
        else $error("external clock used in reset");
    a_rst_drive_len: assert property (
        $fell(reset_pin_oe) |-> (drive_len == 8'(RST_DRIVE_MCLK)))
        else $error("reset pin drive length wrong");
    a_cause_onehot: assert property (
        (state == RS_RUN) && !rst_req.lvd && !rst_req.loc && rst_req.watchdog |=>
        reset_cause_status_register == (8'h01 << CAUSE_COP))
        else $error("reset cause not watchdog");
    a_mode_input: assert property (
        (state != RS_RUN) |=> !debug_pin_oe)
        else $error("debug pin driven in reset");
    a_mode_sample: assert property (
        (state == RS_RELEASE) && reset_pin_in |=>
        (op_mode == ($past(debug_pin_in) ? MODE_NORMAL : MODE_DEBUG)))
        else $error("mode not taken from debug pin");
    a_bit_time: assert property (
        bdc_bit_tick |-> (bdc_seen == 5'(BDC_BIT_CLKS - 1)))
        else $error("bit time not sixteen debug clocks");
    a_speedup_pulse: assert property (
        (state == RS_RUN) && $fell(bdc_drive_low) ##1 !bdc_drive_low[*2] |->
        $past(debug_pin_oe) && $past(debug_pin_out) && debug_pin_oe)
        else $error("no speedup pulse after release");
    a_mode_hold: assert property (
        (state == RS_RUN) && ($past(state) == RS_RUN) |-> $stable(op_mode))
        else $error("mode changed outside reset");

    c_debug_entry: cover property ((state == RS_RELEASE) ##1 (op_mode == MODE_DEBUG));
    c_pin_reset: cover property ((state == RS_RUN) && !reset_pin_in ##1 reset_pin_oe);
    c_cop_reset: cover property ((state == RS_RUN) && rst_req.watchdog);
    c_speedup: cover property ($fell(bdc_drive_low) && (state == RS_RUN));

endmodule

// file: hdl/rmc_pkg.sv
/*
 * rmc_pkg: constants and types for the reset, mode-entry and clock-root block.
 * Assumes a single 100 MHz master clock that stands for the clock generator
 * output; every slower clock is a one-cycle enable derived from it.
 */
package rmc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int MCLK_HZ        = 100_000_000;
    localparam int MCLK_NS        = 10;
    localparam int LPO_HZ         = 1000;
    localparam int LPO_DIV        = MCLK_HZ / LPO_HZ;
    localparam int MCLK_PER_BUS   = 2;
    localparam int RST_DRIVE_BUS  = 34;
    localparam int RST_DRIVE_MCLK = RST_DRIVE_BUS * MCLK_PER_BUS;
    localparam int BDC_BIT_CLKS   = 16;
    localparam int SPEEDUP_NS     = 20;
    localparam int SPEEDUP_CYC    = (SPEEDUP_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int NUM_TIMERS     = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset cause status bit positions and reset value
    localparam int            CAUSE_W     = 8;
    localparam int            CAUSE_LVD   = 1;
    localparam int            CAUSE_LOC   = 2;
    localparam int            CAUSE_ILAD  = 3;
    localparam int            CAUSE_ILOP  = 4;
    localparam int            CAUSE_COP   = 5;
    localparam int            CAUSE_PIN   = 6;
    localparam int            CAUSE_POR   = 7;
    localparam logic [7:0]    CAUSE_RESET = 8'h80;

    ////////////////////////////////////////////////////////////////////////////
    // clock select codes
    localparam logic [1:0] RTC_SEL_LPO = 2'h0;
    localparam logic [1:0] RTC_SEL_EXT = 2'h1;
    localparam logic [1:0] RTC_SEL_INT = 2'h2;
    localparam logic [1:0] RTC_SEL_OFF = 2'h3;
    localparam logic       WDOG_SEL_BUS = 1'h0;
    localparam logic       WDOG_SEL_LPO = 1'h1;
    localparam logic [1:0] TMR_SEL_BUS = 2'h0;
    localparam logic [1:0] TMR_SEL_FIX = 2'h1;
    localparam logic [1:0] TMR_SEL_EXT = 2'h2;
    localparam logic [1:0] TMR_SEL_OFF = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {RS_DRIVE, RS_RELEASE, RS_RUN} rmc_state_t;
    typedef enum logic {MODE_NORMAL, MODE_DEBUG} rmc_mode_t;

    typedef struct packed {
        logic lvd;
        logic loc;
        logic watchdog;
        logic ilop;
        logic ilad;
    } rmc_rst_req_t;

    typedef struct packed {
        logic [1:0] rtc;
        logic       wdog;
        logic       adc_alt;
        logic       can_alt;
        logic [5:0] tmr;
        logic       dbg_link;
    } rmc_clk_sel_t;

    typedef struct packed {
        logic       rtc;
        logic       wdog;
        logic       adc;
        logic       can;
        logic [2:0] tmr;
        logic       bdc;
    } rmc_clk_en_t;

endpackage

// file: dv/rmc_host_model.sv
/*
 * rmc_host_model: the parties on the far side of the reset pin and the debug
 * pin, an outside reset source and a debug host, plus the pull-ups on both.
 * Assumes the bench steers the host through two command levels.
 */
module rmc_host_model
(
    // device side of the pins
    input  wire logic   reset_pin_oe,
    input  wire logic   debug_pin_oe,
    input  wire logic   debug_pin_out,
    // host commands
    input  wire logic   pull_reset,
    input  wire logic   hold_debug_low,
    // resolved pin levels
    output logic        reset_pin_in,
    output logic        debug_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // host reset pull
    // released lines fall back to the pull-up, never to the last value
    assign reset_pin_in = !(reset_pin_oe || pull_reset);

    // open drain
    // a low from either party wins, even over a speedup pulse
    assign debug_pin_in = !hold_debug_low && (!debug_pin_oe || debug_pin_out);
endmodule

// file: dv/rmc_top_bench.sv
/*
 * rmc_top_bench: self-checking bench for rmc_top, with the host model on the
 * reset and debug pins. Assumes the low-power divider is cut to 10 mclk.
 */
module rmc_top_bench
    import rmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LPO_SIM = 10;

    logic                  mclk;
    logic                  rst;
    logic                  ext_ref_clk_en;
    logic                  int_ref_clk_en;
    logic                  fixed_freq_clk_en;
    logic                  debug_link_clk_en;
    logic [NUM_TIMERS-1:0] timer_ext_clk;
    rmc_clk_sel_t          clk_sel;
    logic                  bus_clk_en;
    logic                  lpo_clk_en;
    rmc_clk_en_t           clk_en;
    rmc_rst_req_t          rst_req;
    logic                  reset_pin_in;
    logic                  reset_pin_oe;
    logic                  reset_pin_out;
    logic                  sys_reset;
    logic [CAUSE_W-1:0]    cause;
    rmc_mode_t             op_mode;
    logic                  clkgen_ext_req;
    logic                  clkgen_use_internal;
    logic                  debug_pin_in;
    logic                  debug_pin_out;
    logic                  debug_pin_oe;
    logic                  bdc_drive_low;
    logic                  bdc_bit_run;
    logic                  bdc_bit_tick;
    logic                  pull_reset;
    logic                  hold_debug_low;
    logic [9:0]            probe;
    int                    miscompares;
    int                    comparisons;

    // bus, lpo, then rtc wdog adc can tmr[2:0] bdc
    assign probe = {bus_clk_en, lpo_clk_en, clk_en};

    rmc_top #(.LPO_DIV_P(LPO_SIM)) i_dut (
        .mclk(mclk), .rst(rst), .ext_ref_clk_en(ext_ref_clk_en),
        .int_ref_clk_en(int_ref_clk_en), .fixed_freq_clk_en(fixed_freq_clk_en),
        .debug_link_clk_en(debug_link_clk_en), .timer_ext_clk(timer_ext_clk),
        .clk_sel(clk_sel), .bus_clk_en(bus_clk_en), .lpo_clk_en(lpo_clk_en),
        .clk_en(clk_en), .rst_req(rst_req), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .sys_reset(sys_reset),
        .reset_cause_status_register(cause), .op_mode(op_mode),
        .clkgen_ext_req(clkgen_ext_req), .clkgen_use_internal(clkgen_use_internal),
        .debug_pin_in(debug_pin_in), .debug_pin_out(debug_pin_out),
        .debug_pin_oe(debug_pin_oe), .bdc_drive_low(bdc_drive_low),
        .bdc_bit_run(bdc_bit_run), .bdc_bit_tick(bdc_bit_tick));

    rmc_host_model i_host (
        .reset_pin_oe(reset_pin_oe), .debug_pin_oe(debug_pin_oe),
        .debug_pin_out(debug_pin_out), .pull_reset(pull_reset),
        .hold_debug_low(hold_debug_low), .reset_pin_in(reset_pin_in),
        .debug_pin_in(debug_pin_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int lo, input int hi, input string what);
        comparisons++;
        if (got < lo || got > hi)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s count %0d not in %0d..%0d", $time, what, got,
                     lo, hi);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // any reset: power-on when por, else a request or a pin pull taken in run
    task automatic t_reset(input logic por, input rmc_rst_req_t req, input logic pin,
                           input logic dbg, input int pos);
        int n;
        n = 0;
        @(negedge mclk);
        rst = por;
        rst_req = req;
        pull_reset = pin;
        hold_debug_low = dbg;
        repeat (por ? 3 : 1) @(negedge mclk);
        rst = 1'b0;
        rst_req = '0;
        pull_reset = 1'b0;
        check_val(cause, 8'(1 << pos), "cause bit");
        check_val(debug_pin_oe, 1'b0, "mode pin is input");
        check_val(clkgen_use_internal, 1'b1, "internal clock");
        check_val({reset_pin_oe, reset_pin_out}, 2'h2, "pin driven low");
        while (reset_pin_oe === 1'b1 && n < 200)
        begin
            n++;
            @(negedge mclk);
        end
        check_count(n, RST_DRIVE_MCLK - 1, RST_DRIVE_MCLK + 1, "pin drive");
        for (int i = 0; i < 10 && sys_reset !== 1'b0; i++)
            @(negedge mclk);
        check_val(sys_reset, 1'b0, "reset ends");
        check_val(op_mode, dbg ? MODE_DEBUG : MODE_NORMAL, "mode entry");
        hold_debug_low = !dbg;
        repeat (3) @(negedge mclk);
        hold_debug_low = 1'b0;
        check_val(op_mode, dbg ? MODE_DEBUG : MODE_NORMAL, "mode held");
    endtask

    task automatic count_sel(input rmc_clk_sel_t sel, input int idx, input int exp);
        int n;
        n = 0;
        @(negedge mclk);
        clk_sel = sel;
        repeat (20)
        begin
            #2;
            n += int'(probe[idx] === 1'b1);
            @(negedge mclk);
        end
        check_count(n, exp, exp, "enable count");
    endtask

    task automatic t_tmr_ext;
        int         n;
        logic [2:0] prev;
        n = 0;
        @(negedge mclk);
        clk_sel = '{tmr: {3{TMR_SEL_EXT}}, default: '0};
        #2;
        prev = clk_en.tmr;
        for (int i = 0; i < 60; i++)
        begin
            @(negedge mclk);
            if (i < 40 && i % 4 == 0)
                timer_ext_clk = ~timer_ext_clk;
            #2;
            n += $countones(clk_en.tmr & ~prev);
            prev = clk_en.tmr;
        end
        check_count(n, 15, 15, "timer edges");
    endtask

    task automatic t_tick(input logic link);
        int n;
        int at;
        n = 0;
        at = -1;
        @(negedge mclk);
        clk_sel = '{dbg_link: link, default: '0};
        bdc_bit_run = 1'b1;
        for (int i = 0; i < 100 && at < 0; i++)
        begin
            debug_link_clk_en = (i % 3 == 0);
            #2;
            n += int'(clk_en.bdc === 1'b1);
            if (bdc_bit_tick === 1'b1)
                at = n;
            @(negedge mclk);
        end
        bdc_bit_run = 1'b0;
        debug_link_clk_en = 1'b0;
        check_count(at, BDC_BIT_CLKS, BDC_BIT_CLKS, "bit tick");
    endtask

    task automatic t_dbg_pin;
        @(negedge mclk);
        bdc_drive_low = 1'b1;
        @(negedge mclk);
        check_val({debug_pin_oe, debug_pin_in}, 2'b10, "pin pulled low");
        bdc_drive_low = 1'b0;
        repeat (SPEEDUP_CYC)
        begin
            @(negedge mclk);
            check_val({debug_pin_oe, debug_pin_out}, 2'b11, "speedup");
        end
        @(negedge mclk);
        check_val({debug_pin_oe, debug_pin_in}, 2'b01, "pin released");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #(MCLK_NS / 2) mclk = ~mclk;
    end

    initial
    begin
        repeat (8000) @(posedge mclk);
        miscompares++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        int pos[5];
        pos = '{CAUSE_LVD, CAUSE_LOC, CAUSE_COP, CAUSE_ILOP, CAUSE_ILAD};
        rst = 1'b1;
        {ext_ref_clk_en, int_ref_clk_en, fixed_freq_clk_en, debug_link_clk_en} = 4'hB;
        debug_link_clk_en = 1'b0;
        timer_ext_clk = '0;
        clk_sel = '0;
        rst_req = '0;
        {clkgen_ext_req, bdc_drive_low, bdc_bit_run, pull_reset, hold_debug_low} = '0;
        miscompares = 0;
        comparisons = 0;
        t_reset(1'b1, '0, 1'b0, 1'b0, CAUSE_POR);
        clkgen_ext_req = 1'b1;
        repeat (2) @(negedge mclk);
        check_val(clkgen_use_internal, 1'b0, "external clock");
        count_sel('{default: '0}, 9, 10);
        count_sel('{default: '0}, 8, 20 / LPO_SIM);
        count_sel('{default: '0}, 7, 20 / LPO_SIM);
        count_sel('{wdog: WDOG_SEL_LPO, default: '0}, 6, 20 / LPO_SIM);
        count_sel('{wdog: WDOG_SEL_BUS, default: '0}, 6, 10);
        count_sel('{rtc: RTC_SEL_EXT, default: '0}, 7, 20);
        count_sel('{rtc: RTC_SEL_INT, default: '0}, 7, 0);
        count_sel('{rtc: RTC_SEL_OFF, default: '0}, 7, 0);
        count_sel('{adc_alt: 1'b1, default: '0}, 5, 20);
        count_sel('{can_alt: 1'b1, default: '0}, 4, 20);
        count_sel('{dbg_link: 1'b0, default: '0}, 0, 10);
        count_sel('{dbg_link: 1'b1, default: '0}, 0, 0);
        for (int t = 1; t < 4; t++)
        begin
            count_sel('{tmr: {3{TMR_SEL_FIX}}, default: '0}, t, 20);
            count_sel('{tmr: {3{TMR_SEL_BUS}}, default: '0}, t, 10);
            count_sel('{tmr: {3{TMR_SEL_OFF}}, default: '0}, t, 0);
        end
        {ext_ref_clk_en, int_ref_clk_en} = 2'h1;
        count_sel('{rtc: RTC_SEL_INT, default: '0}, 7, 20);
        count_sel('{rtc: RTC_SEL_EXT, default: '0}, 7, 0);
        t_tmr_ext();
        t_tick(1'b0);
        t_tick(1'b1);
        t_dbg_pin();
        for (int i = 0; i < 5; i++)
            t_reset(1'b0, rmc_rst_req_t'(5'h10 >> i), 1'b0, 1'b0, pos[i]);
        t_reset(1'b0, 5'h1F, 1'b0, 1'b0, CAUSE_LVD);
        t_reset(1'b0, '0, 1'b1, 1'b1, CAUSE_PIN);
        t_dbg_pin();
        t_reset(1'b0, 5'h04, 1'b0, 1'b0, CAUSE_COP);
        stop_test();
    end
endmodule
